// file: src/dtc_pkg.sv
// package: register map, field layout, reset values and divide counts of the timer block
package dtc_pkg;

   // ****************************************************************
   // register addresses on the special function register port
   // ****************************************************************
   localparam logic [7:0] ADR_POWER_CONTROL      = 8'h87;
   localparam logic [7:0] ADR_TIMER_CONTROL      = 8'h88;
   localparam logic [7:0] ADR_TIMER_MODE_CONTROL = 8'h89;
   localparam logic [7:0] ADR_TIMER0_LOW_BYTE    = 8'h8a;
   localparam logic [7:0] ADR_TIMER1_LOW_BYTE    = 8'h8b;
   localparam logic [7:0] ADR_TIMER0_HIGH_BYTE   = 8'h8c;
   localparam logic [7:0] ADR_TIMER1_HIGH_BYTE   = 8'h8d;
   localparam logic [7:0] ADR_CLOCK_CONTROL      = 8'h8e;

   // ****************************************************************
   // field positions; per-timer fields step by the given stride
   // ****************************************************************
   localparam int TCTL_RUN_POS      = 4;   // timer 0 run bit, timer 1 at +2
   localparam int TCTL_OVF_POS      = 5;   // timer 0 overflow flag, timer 1 at +2
   localparam int TCTL_TYPE_POS     = 0;   // ext irq 0 trigger type, irq 1 at +2
   localparam int TCTL_REQ_POS      = 1;   // ext irq 0 request flag, irq 1 at +2
   localparam int TCTL_STRIDE       = 2;
   localparam int TMC_NIBBLE        = 4;   // timer 1 uses the upper nibble
   localparam int TMC_GATE_POS      = 3;
   localparam int TMC_COUNTER_POS   = 2;
   localparam int TMC_MODE_POS      = 0;   // two-bit mode field
   localparam int CLKC_DIV_POS      = 3;   // timer 0 divider select, timer 1 at +1
   localparam int PWRC_POWER_DN_POS = 1;
   localparam int PWRC_HALT_POS     = 0;

   // ****************************************************************
   // reset values and read-back constants
   // ****************************************************************
   localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
   localparam logic [7:0] RST_TIMER_MODE    = 8'h00;
   localparam logic [7:0] RST_COUNT_BYTE    = 8'h00;
   localparam logic [7:0] RST_CLOCK_CONTROL = 8'h01;
   localparam logic [7:0] PWRC_UNUSED_MASK  = 8'h30;  // unimplemented bits read high
   localparam logic [7:0] UNMAPPED_READ     = 8'hff;

   // ****************************************************************
   // machine-cycle divide counts
   // ****************************************************************
   localparam int DIV_FAST_CNT = 4;
   localparam int DIV_SLOW_CNT = 12;

   typedef enum logic [1:0]
   {
      MODE_13BIT  = 2'b00,
      MODE_16BIT  = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT  = 2'b11
   } dtc_mode_e;

endpackage : dtc_pkg

// file: src/dtc_evt_if.sv
// interface: tick and pin-edge events passed from the helpers to the timer core
`timescale 1ns/100ps
interface dtc_evt_if;
   logic       tick_fast;   // one pulse every fast divide count
   logic       tick_slow;   // one pulse every slow divide count
   logic [3:0] fall;        // count pin 0/1, ext irq pin 0/1 falling edges

   modport div  (output tick_fast, output tick_slow);
   modport det  (output fall);
   modport core (input tick_fast, input tick_slow, input fall);
endinterface : dtc_evt_if

// file: src/dtc_prescale.sv
// module: free-running machine-cycle divider giving fast and slow tick pulses
`timescale 1ns/100ps
module dtc_prescale
   import dtc_pkg::*;
#(
   parameter int FAST = DIV_FAST_CNT,
   parameter int SLOW = DIV_SLOW_CNT
)
(
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   dtc_evt_if.div    evt
);
   localparam logic [3:0] FAST_LAST = 4'(FAST - 1);
   localparam logic [3:0] SLOW_LAST = 4'(SLOW - 1);

   if (FAST < 2 || SLOW <= FAST || SLOW > 16)
   begin : g_bad
      $error("dtc_prescale: divide counts out of range");
   end

   logic [3:0] fast_cnt_ff;
   logic [3:0] slow_cnt_ff;

   // counters run through idle and power-down; counting is gated in the core
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         fast_cnt_ff   <= 4'h0;
         slow_cnt_ff   <= 4'h0;
         evt.tick_fast <= 1'b0;
         evt.tick_slow <= 1'b0;
      end
      else
      begin
         fast_cnt_ff   <= (fast_cnt_ff == FAST_LAST) ? 4'h0 : fast_cnt_ff + 4'h1;
         slow_cnt_ff   <= (slow_cnt_ff == SLOW_LAST) ? 4'h0 : slow_cnt_ff + 4'h1;
         evt.tick_fast <= (fast_cnt_ff == FAST_LAST);
         evt.tick_slow <= (slow_cnt_ff == SLOW_LAST);
      end
   end
endmodule : dtc_prescale

// file: src/dtc_fall_det.sv
// module: falling-edge detection on the count and external interrupt pins
`timescale 1ns/100ps
module dtc_fall_det
#(
   parameter int N = 4
)
(
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   input  wire logic [N-1:0] pin_i,
   dtc_evt_if.det            evt
);
   if (N != 4)
   begin : g_bad
      $error("dtc_fall_det: interface carries exactly four pins");
   end

   logic [N-1:0] prev_ff;

   // pins idle high, so reset to one; a pin already low at release then reads as one falling edge
   for (genvar i = 0; i < N; i++)
   begin : g_pin
      always_ff @(posedge core_clk_i)
      begin
         if (rst_i)
            prev_ff[i] <= 1'b1;
         else
            prev_ff[i] <= pin_i[i];
      end
      assign evt.fall[i] = prev_ff[i] & ~pin_i[i];
   end
endmodule : dtc_fall_det

// file: src/dtc_timer_top.sv
// module: two timer/counters with external interrupt flags behind the register port
`timescale 1ns/100ps
module dtc_timer_top
   import dtc_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic      [7:0] sfr_rdata_o,
   input  wire logic [1:0] count_pin_i,
   input  wire logic       ext_irq0_pin_i,
   input  wire logic       ext_irq1_pin_i,
   input  wire logic [1:0] timer_isr_ack_i,
   input  wire logic [1:0] ext_irq_vector_ack_i,
   output logic            timer0_overflow_flag_o,
   output logic            timer1_overflow_flag_o,
   output logic            ext_irq0_request_flag_o,
   output logic            ext_irq1_request_flag_o,
   output logic            cpu_halt_o,
   output logic            power_down_o
);
   // ****************************************************************
   // helpers: divider ticks and pin edges
   // ****************************************************************
   dtc_evt_if evt ();

   dtc_prescale #(.FAST(DIV_FAST_CNT), .SLOW(DIV_SLOW_CNT)) u_div
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .evt        (evt)
   );

   dtc_fall_det #(.N(4)) u_edge
   (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .pin_i      ({ext_irq1_pin_i, ext_irq0_pin_i, count_pin_i}),
      .evt        (evt)
   );

   // ****************************************************************
   // register state
   // ****************************************************************
   logic [7:0] pwr_ctl_ff;
   logic [7:0] tmc_ff;
   logic [7:0] clkc_ff;
   logic [7:0] tl_ff [2];
   logic [7:0] th_ff [2];
   logic [1:0] run_ff;
   logic [1:0] ovf_ff;
   logic [1:0] req_ff;
   logic [1:0] type_ff;

   // ****************************************************************
   // register port decode
   // ****************************************************************
   wire wr_pwrc = sfr_wr_i && (sfr_addr_i == ADR_POWER_CONTROL);
   wire wr_tctl = sfr_wr_i && (sfr_addr_i == ADR_TIMER_CONTROL);
   wire wr_tmc  = sfr_wr_i && (sfr_addr_i == ADR_TIMER_MODE_CONTROL);
   wire wr_clkc = sfr_wr_i && (sfr_addr_i == ADR_CLOCK_CONTROL);
   wire [1:0] wr_tl = {sfr_wr_i && (sfr_addr_i == ADR_TIMER1_LOW_BYTE),
                       sfr_wr_i && (sfr_addr_i == ADR_TIMER0_LOW_BYTE)};
   wire [1:0] wr_th = {sfr_wr_i && (sfr_addr_i == ADR_TIMER1_HIGH_BYTE),
                       sfr_wr_i && (sfr_addr_i == ADR_TIMER0_HIGH_BYTE)};

   // ****************************************************************
   // per-timer controls and increment enables
   // ****************************************************************
   wire       frozen  = pwr_ctl_ff[PWRC_POWER_DN_POS];
   wire [1:0] irq_pin = {ext_irq1_pin_i, ext_irq0_pin_i};
   dtc_mode_e mode [2];
   logic [1:0] gate;
   logic [1:0] cnt_sel;
   logic [1:0] div_fast;
   logic [1:0] runs;
   logic [1:0] tick;
   logic [1:0] inc;

   // the generate keeps both timers' control decode identical
   for (genvar i = 0; i < 2; i++)
   begin : g_ctl
      assign mode[i]     = dtc_mode_e'(tmc_ff[i*TMC_NIBBLE+TMC_MODE_POS +: 2]);
      assign gate[i]     = tmc_ff[i*TMC_NIBBLE+TMC_GATE_POS];
      assign cnt_sel[i]  = tmc_ff[i*TMC_NIBBLE+TMC_COUNTER_POS];
      assign div_fast[i] = clkc_ff[CLKC_DIV_POS+i];
      assign runs[i]     = run_ff[i] & (~gate[i] | irq_pin[i]);
      assign tick[i]     = div_fast[i] ? evt.tick_fast : evt.tick_slow;
      assign inc[i]      = runs[i] & ~frozen & (cnt_sel[i] ? evt.fall[i] : tick[i]);
   end

   // split high byte: timer 1 run bit, timer 0 internal ticks only
   wire inc_split = (mode[0] == MODE_SPLIT) & run_ff[1] & ~frozen & tick[0];

   // ****************************************************************
   // count step: returns {overflow, high, low}
   // ****************************************************************
   function automatic logic [16:0] dtc_step(input dtc_mode_e m, input logic [7:0] hi,
                                            input logic [7:0] lo);
      logic [12:0] v13;
      logic [15:0] v16;
      logic [16:0] r;
      v13 = {hi, lo[4:0]} + 13'h1;
      v16 = {hi, lo} + 16'h1;
      case (m)
         MODE_13BIT:  r = {&{hi, lo[4:0]}, v13[12:5], lo[7:5], v13[4:0]};
         MODE_16BIT:  r = {&{hi, lo}, v16};
         MODE_RELOAD: r = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
         default:     r = {1'b0, hi, lo};
      endcase
      return r;
   endfunction : dtc_step

   // ****************************************************************
   // next counts; a software byte write wins over the count
   // ****************************************************************
   logic [7:0] nxt_tl [2];
   logic [7:0] nxt_th [2];
   logic [1:0] ovf_hit;
   logic       split_hit;
   logic [16:0] step0;
   logic [16:0] step1;

   always_comb
   begin
      step0 = dtc_step(mode[0], th_ff[0], tl_ff[0]);
      step1 = dtc_step(mode[1], th_ff[1], tl_ff[1]);
      nxt_tl[0] = tl_ff[0];
      nxt_th[0] = th_ff[0];
      nxt_tl[1] = tl_ff[1];
      nxt_th[1] = th_ff[1];
      ovf_hit   = 2'b00;
      split_hit = 1'b0;
      if (mode[0] == MODE_SPLIT)
      begin
         if (inc[0])
            {ovf_hit[0], nxt_tl[0]} = {1'b0, tl_ff[0]} + 9'h001;
         if (inc_split)
            {split_hit, nxt_th[0]} = {1'b0, th_ff[0]} + 9'h001;
      end
      else if (inc[0])
         {ovf_hit[0], nxt_th[0], nxt_tl[0]} = step0;
      // mode 3 on timer 1 leaves the count untouched
      if (inc[1] && mode[1] != MODE_SPLIT)
         {ovf_hit[1], nxt_th[1], nxt_tl[1]} = step1;
      for (int i = 0; i < 2; i++)
      begin
         if (wr_tl[i])
            nxt_tl[i] = sfr_wdata_i;
         if (wr_th[i])
            nxt_th[i] = sfr_wdata_i;
      end
   end

   // while timer 0 is split its high byte owns timer 1's flag
   wire [1:0] ovf_set = {(mode[0] == MODE_SPLIT) ? split_hit : ovf_hit[1], ovf_hit[0]};

   // ****************************************************************
   // flags: a hardware set wins over a clear in the same cycle
   // ****************************************************************
   logic [1:0] nxt_ovf;
   logic [1:0] nxt_req;
   logic [1:0] nxt_run;
   logic [1:0] nxt_type;

   for (genvar i = 0; i < 2; i++)
   begin : g_flag
      wire sw_ovf = sfr_wdata_i[TCTL_OVF_POS+i*TCTL_STRIDE];
      wire sw_req = sfr_wdata_i[TCTL_REQ_POS+i*TCTL_STRIDE];
      wire kept_ovf = wr_tctl ? sw_ovf : (ovf_ff[i] & ~timer_isr_ack_i[i]);
      wire kept_req = wr_tctl ? sw_req : (req_ff[i] & ~ext_irq_vector_ack_i[i]);
      assign nxt_ovf[i] = ovf_set[i] | kept_ovf;
      // edge type latches a falling edge; level type tracks the pin low
      assign nxt_req[i] = type_ff[i] ? ((evt.fall[2+i] & ~frozen) | kept_req)
                                     : ~irq_pin[i];
      assign nxt_run[i] = wr_tctl ? sfr_wdata_i[TCTL_RUN_POS+i*TCTL_STRIDE] : run_ff[i];
      assign nxt_type[i] = wr_tctl ? sfr_wdata_i[TCTL_TYPE_POS+i*TCTL_STRIDE]
                                   : type_ff[i];
   end

   // a new external request wakes from power-down; any new flag ends idle
   wire new_ext = |(nxt_req & ~req_ff);
   wire new_any = new_ext | (|(nxt_ovf & ~ovf_ff));
   logic [7:0] nxt_pwr;
   always_comb
   begin
      nxt_pwr = wr_pwrc ? sfr_wdata_i : pwr_ctl_ff;
      if (new_ext)
         nxt_pwr[PWRC_POWER_DN_POS] = 1'b0;
      if (new_any)
         nxt_pwr[PWRC_HALT_POS] = 1'b0;
   end

   // ****************************************************************
   // read mux; unmapped addresses read all ones
   // ****************************************************************
   logic [7:0] tctl_rd;
   for (genvar i = 0; i < 2; i++)
   begin : g_rd
      assign tctl_rd[TCTL_OVF_POS+i*TCTL_STRIDE]  = ovf_ff[i];
      assign tctl_rd[TCTL_RUN_POS+i*TCTL_STRIDE]  = run_ff[i];
      assign tctl_rd[TCTL_REQ_POS+i*TCTL_STRIDE]  = req_ff[i];
      assign tctl_rd[TCTL_TYPE_POS+i*TCTL_STRIDE] = type_ff[i];
   end
   wire [7:0] rd_mux =
      (sfr_addr_i == ADR_POWER_CONTROL)      ? (pwr_ctl_ff | PWRC_UNUSED_MASK) :
      (sfr_addr_i == ADR_TIMER_CONTROL)      ? tctl_rd :
      (sfr_addr_i == ADR_TIMER_MODE_CONTROL) ? tmc_ff :
      (sfr_addr_i == ADR_TIMER0_LOW_BYTE)    ? tl_ff[0] :
      (sfr_addr_i == ADR_TIMER1_LOW_BYTE)    ? tl_ff[1] :
      (sfr_addr_i == ADR_TIMER0_HIGH_BYTE)   ? th_ff[0] :
      (sfr_addr_i == ADR_TIMER1_HIGH_BYTE)   ? th_ff[1] :
      (sfr_addr_i == ADR_CLOCK_CONTROL)      ? clkc_ff : UNMAPPED_READ;

   // ****************************************************************
   // state registers
   // ****************************************************************
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         pwr_ctl_ff  <= RST_POWER_CONTROL;
         tmc_ff      <= RST_TIMER_MODE;
         clkc_ff     <= RST_CLOCK_CONTROL;
         run_ff      <= 2'b00;
         ovf_ff      <= 2'b00;
         req_ff      <= 2'b00;
         type_ff     <= 2'b00;
         sfr_rdata_o <= 8'h00;
      end
      else
      begin
         pwr_ctl_ff  <= nxt_pwr;
         tmc_ff      <= wr_tmc ? sfr_wdata_i : tmc_ff;
         clkc_ff     <= wr_clkc ? sfr_wdata_i : clkc_ff;
         run_ff      <= nxt_run;
         ovf_ff      <= nxt_ovf;
         req_ff      <= nxt_req;
         type_ff     <= nxt_type;
         sfr_rdata_o <= sfr_rd_i ? rd_mux : sfr_rdata_o;
      end
   end

   // count bytes, one set per timer
   for (genvar i = 0; i < 2; i++)
   begin : g_cnt
      always_ff @(posedge core_clk_i)
      begin
         if (rst_i)
         begin
            tl_ff[i] <= RST_COUNT_BYTE;
            th_ff[i] <= RST_COUNT_BYTE;
         end
         else
         begin
            tl_ff[i] <= nxt_tl[i];
            th_ff[i] <= nxt_th[i];
         end
      end
   end

   // outputs are the flag and control flip-flops themselves
   assign timer0_overflow_flag_o  = ovf_ff[0];
   assign timer1_overflow_flag_o  = ovf_ff[1];
   assign ext_irq0_request_flag_o = req_ff[0];
   assign ext_irq1_request_flag_o = req_ff[1];
   assign cpu_halt_o              = pwr_ctl_ff[PWRC_HALT_POS];
   assign power_down_o            = pwr_ctl_ff[PWRC_POWER_DN_POS];

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_reload_wrap;
      mode[0] == MODE_RELOAD && tl_ff[0] == 8'hff && inc[0] && !wr_tl[0] && !wr_th[0];
   endsequence

   a_run_off_holds: assert property (
      !run_ff[0] && mode[0] != MODE_SPLIT && !wr_tl[0] && !wr_th[0]
      |=> $stable(tl_ff[0]) && $stable(th_ff[0]))
      else $error("timer 0 counted while stopped");
   a_gate_blocks: assert property (
      gate[0] && !ext_irq0_pin_i && mode[0] != MODE_SPLIT && !wr_tl[0] && !wr_th[0]
      |=> $stable(tl_ff[0]) && $stable(th_ff[0]))
      else $error("gated timer 0 counted with its pin low");
   a_ovf16_flag: assert property (
      mode[0] == MODE_16BIT && inc[0] && {th_ff[0], tl_ff[0]} == 16'hffff
      && !wr_tl[0] && !wr_th[0]
      |=> ovf_ff[0] && tl_ff[0] == 8'h00 && th_ff[0] == 8'h00)
      else $error("16-bit wrap did not set flag and clear count");
   a_reload_step: assert property (
      s_reload_wrap |=> ovf_ff[0] && tl_ff[0] == $past(th_ff[0]) && $stable(th_ff[0]))
      else $error("auto-reload wrap wrong");
   a_mode0_carry: assert property (
      mode[1] == MODE_13BIT && mode[0] != MODE_SPLIT && inc[1] && tl_ff[1][4:0] == 5'h1f
      && !wr_tl[1] && !wr_th[1] && !wr_tctl
      |=> th_ff[1] == $past(th_ff[1]) + 8'h01 && tl_ff[1][4:0] == 5'h00
      && tl_ff[1][7:5] == $past(tl_ff[1][7:5])
      && (($past(th_ff[1]) == 8'hff) ? ovf_ff[1] : !$rose(ovf_ff[1])))
      else $error("prescaler carry into high byte wrong");
   a_t1_mode3_hold: assert property (
      mode[1] == MODE_SPLIT && !wr_tl[1] && !wr_th[1] |=> $stable(tl_ff[1]))
      else $error("timer 1 moved in mode 3");
   a_edge_request: assert property (
      type_ff[0] && evt.fall[2] && !frozen |=> req_ff[0])
      else $error("falling edge missed on external request 0");
   a_level_follow: assert property (
      !type_ff[1] ##1 !type_ff[1] |-> req_ff[1] == !$past(ext_irq1_pin_i))
      else $error("level request does not follow pin");
   a_slow_period: assert property (
      evt.tick_slow |=> !evt.tick_slow [*8] ##1 !evt.tick_slow ##1 !evt.tick_slow
      ##1 !evt.tick_slow ##1 evt.tick_slow)
      else $error("slow tick period is not twelve");
   a_fast_period: assert property (
      evt.tick_fast |=> !evt.tick_fast [*3] ##1 evt.tick_fast)
      else $error("fast tick period is not four");
   a_freeze_hold: assert property (
      frozen && !wr_tl[0] && !wr_th[0] |=> $stable(tl_ff[0]) && $stable(th_ff[0]))
      else $error("timer 0 moved in power-down");
endmodule : dtc_timer_top

// file: testbench/dtc_pin_model.sv
// partner: count pins and external interrupt pins driven from bench requests
`timescale 1ns/100ps
module dtc_pin_model
(
   input  wire logic       core_clk_i,
   input  wire logic [1:0] fall_i,
   input  wire logic [1:0] irq_lvl_i,
   output logic      [1:0] count_pin_o,
   output logic      [1:0] irq_pin_o
);
   // ****************
   // pin drivers
   // ****************
   logic [3:0] pin_ff = 4'hf;   // idle high, as behind a pull-up

   // a count request holds its pin low while asked, so the high-low pair is seen whole
   always @(posedge core_clk_i)
   begin
      pin_ff <= {irq_lvl_i, ~fall_i};
   end
   assign count_pin_o = pin_ff[1:0];
   assign irq_pin_o   = pin_ff[3:2];
endmodule : dtc_pin_model

// file: testbench/tb.sv
// testbench: register map, count modes, gating, power states and interrupt flags
`timescale 1ns/100ps
module tb;
   import dtc_pkg::*;
   // ****************
   // bench plumbing
   // ****************
   logic       core_clk_i = 0, rst_i = 1, wr = 0, rd = 0, rd_q, hlt, pdn;
   logic [7:0] a = 0, wd = 0, rdat, v;
   logic [1:0] tack = 0, vack = 0, fall = 0, lvl = 3, cpin, ip, tf, rf;
   logic [7:0] expq[$];
   logic [7:0] elo[3] = '{8'he0, 8'h00, 8'hff};
   int         errors = 0, checked = 0, c, m, dv;

   // 25 MHz core clock
   always #20 core_clk_i = ~core_clk_i;

   dtc_timer_top uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_addr_i(a), .sfr_wr_i(wr),
      .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .count_pin_i(cpin),
      .ext_irq0_pin_i(ip[0]), .ext_irq1_pin_i(ip[1]), .timer_isr_ack_i(tack),
      .ext_irq_vector_ack_i(vack), .timer0_overflow_flag_o(tf[0]),
      .timer1_overflow_flag_o(tf[1]), .ext_irq0_request_flag_o(rf[0]),
      .ext_irq1_request_flag_o(rf[1]), .cpu_halt_o(hlt), .power_down_o(pdn));
   dtc_pin_model pins (.core_clk_i(core_clk_i), .fall_i(fall), .irq_lvl_i(lvl),
      .count_pin_o(cpin), .irq_pin_o(ip));

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   task automatic chk(logic [7:0] got, logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chkb(logic got, logic exp);
      chk({7'h00, got}, {7'h00, exp});
   endtask : chkb

   // inputs always move 1 ns after the rising edge
   task automatic step(int k = 1);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask : step

   // strobes drop for a cycle between accesses so no signal is set twice at once
   task automatic wreg(logic [7:0] ad, logic [7:0] d);
      a = ad;
      wd = d;
      wr = 1;
      step();
      wr = 0;
      step();
   endtask : wreg

   task automatic rreg(logic [7:0] ad, logic [7:0] exp);
      a = ad;
      rd = 1;
      expq.push_back(exp);
      step();
      rd = 0;
      step();
   endtask : rreg

   // read data stands 2 ns after the edge that samples the read strobe; oldest note is the match
   always @(posedge core_clk_i)
   begin
      rd_q = rd;
      #2;
      if (rd_q)
         chk(rdat, expq.pop_front());
   end

   // bounded wait for an overflow flag; a missed flag that must come ends the run
   task automatic waitf(int t, int lim, bit must);
      c = 0;
      while (tf[t] !== 1'h1 && c < lim)
      begin
         step();
         c++;
      end
      if (must && tf[t] !== 1'h1)
      begin
         errors++;
         test_done();
      end
   endtask : waitf

   task automatic arm(int t, logic [7:0] md, logic [7:0] ck);
      wreg(ADR_TIMER_MODE_CONTROL, md);
      wreg(ADR_CLOCK_CONTROL, ck);
      wreg(ADR_TIMER0_HIGH_BYTE + 8'(t), 8'hff);
      wreg(ADR_TIMER0_LOW_BYTE + 8'(t), 8'hff);
      wreg(ADR_TIMER_CONTROL, 8'h10 << 2 * t);
   endtask : arm

   // ****************
   // scenarios
   // ****************
   initial
   begin
      dv = $urandom(32'h8ae1);
      step(12);
      rst_i = 0;
      step();
      rreg(ADR_TIMER_CONTROL, 8'h00);
      rreg(ADR_CLOCK_CONTROL, RST_CLOCK_CONTROL);
      rreg(ADR_POWER_CONTROL, RST_POWER_CONTROL | PWRC_UNUSED_MASK);
      rreg(8'h80, UNMAPPED_READ);
      for (int i = 0; i < 4; i++)
      begin
         v = 8'($urandom);
         wreg(ADR_TIMER0_LOW_BYTE + 8'(i), v);
         rreg(ADR_TIMER0_LOW_BYTE + 8'(i), v);
      end
      // modes 0 to 2 on both timers; the divider is random, the period is measured in mode 2
      for (int k = 0; k < 6; k++)
      begin
         m = k / 2;
         dv = $urandom % 2;
         arm(k % 2, 8'(m << (4 * (k % 2))), 8'(dv << (3 + k % 2)));
         waitf(k % 2, 30, 1);
         if (m == 2)
         begin
            tack[k % 2] = 1;
            step();
            tack = 0;
            waitf(k % 2, 30, 1);
            chk(8'(c + 1), dv ? 8'h04 : 8'h0c);
         end
         wreg(ADR_TIMER_CONTROL, 8'h20 << 2 * (k % 2));
         rreg(ADR_TIMER0_LOW_BYTE + 8'(k % 2), elo[m]);
         rreg(ADR_TIMER0_HIGH_BYTE + 8'(k % 2), m == 2 ? 8'hff : 8'h00);
         chkb(tf[k % 2], 1'h1);
         tack[k % 2] = 1;
         step();
         tack = 0;
         step();
         chkb(tf[k % 2], 1'h0);
      end
      // timer 1 in mode 3 holds, then a low gate pin blocks timer 0
      arm(1, 8'h30, 8'h10);
      waitf(1, 30, 0);
      chkb(tf[1], 1'h0);
      rreg(ADR_TIMER1_LOW_BYTE, 8'hff);
      lvl = 0;
      arm(0, 8'h0a, 8'h08);
      waitf(0, 30, 0);
      chkb(tf[0], 1'h0);
      lvl = 3;
      waitf(0, 30, 1);
      // counter mode ignores ticks and counts one pin fall
      for (int i = 0; i < 2; i++)
      begin
         arm(i, 8'(8'h05 << (4 * i)), 8'h18);
         waitf(i, 30, 0);
         chkb(tf[i], 1'h0);
         fall[i] = 1;
         step(2);
         fall = 0;
         waitf(i, 6, 1);
      end
      // split timer 0: low byte on its own run bit, high byte on timer 1's, setting flag 1
      arm(0, 8'h03, 8'h08);
      waitf(0, 30, 1);
      wreg(ADR_TIMER0_HIGH_BYTE, 8'hff);
      wreg(ADR_TIMER_CONTROL, 8'h40);
      waitf(1, 30, 1);
      chkb(tf[0], 1'h0);
      rreg(ADR_TIMER0_HIGH_BYTE, 8'h00);
      rreg(ADR_TIMER0_LOW_BYTE, 8'h00);
      // idle keeps counting, power-down freezes the count
      wreg(ADR_POWER_CONTROL, 8'h01);
      chkb(hlt, 1'h1);
      arm(0, 8'h02, 8'h08);
      waitf(0, 30, 1);
      wreg(ADR_POWER_CONTROL, 8'h02);
      chkb(pdn, 1'h1);
      arm(0, 8'h02, 8'h08);
      waitf(0, 30, 0);
      chkb(tf[0], 1'h0);
      rreg(ADR_TIMER0_LOW_BYTE, 8'hff);
      wreg(ADR_POWER_CONTROL, 8'h00);
      waitf(0, 30, 1);
      // edge-type request latches until vectored, level-type follows the pin
      for (int i = 0; i < 2; i++)
      begin
         wreg(ADR_TIMER_CONTROL, 8'(1 << (2 * i)));
         lvl[i] = 0;
         step(4);
         lvl[i] = 1;
         step(4);
         chkb(rf[i], 1'h1);
         vack[i] = 1;
         step();
         vack = 0;
         step();
         chkb(rf[i], 1'h0);
         wreg(ADR_TIMER_CONTROL, 8'h00);
         lvl[i] = 0;
         step(3);
         chkb(rf[i], 1'h1);
         lvl[i] = 1;
         step(3);
         chkb(rf[i], 1'h0);
      end
      test_done();
   end
endmodule : tb
